// file: design/edc_pkg.sv
// Purpose: Constants for the extended-data-out memory strobe controller.
// Assumes: 25 MHz controller clock, 40 ns period.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package edc_pkg;
    localparam int CLK_PERIOD_PS  = 40000;
    localparam int RAS_MIN_NS     = 60;
    localparam int RP_MIN_NS      = 40;
    localparam int CP_MIN_NS      = 10;
    localparam int AR_MIN_NS      = 40;
    localparam int ACCESS_MAX_NS  = 60;
    localparam int WAKE_US        = 200;
    localparam int REF_PERIOD_MS  = 16;
    localparam int REF_ROWS       = 1024;
    localparam int WAKE_CYCLES    = 8;
    localparam int RAS_CYC        = (RAS_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RP_CYC         = (RP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CP_CYC         = (CP_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AR_CYC         = (AR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACCESS_CYC     = (ACCESS_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WAKE_CYC_DEF   = WAKE_US * 1000000 / CLK_PERIOD_PS;
    localparam int REF_INT_CYC_DEF =
        (REF_PERIOD_MS * 1000000 / REF_ROWS) * 1000 / CLK_PERIOD_PS;
    localparam int ADDR_W         = 10;
    localparam int DATA_W         = 16;
    localparam int BYTE_W         = 8;
    typedef enum logic [3:0] {
        EDC_WAKE,
        EDC_INIT_RAS,
        EDC_INIT_PRE,
        EDC_IDLE,
        EDC_ROW,
        EDC_COL,
        EDC_HOLD,
        EDC_REF_CAS,
        EDC_REF_RAS,
        EDC_PRE
    } edc_state_t;
endpackage : edc_pkg

// file: design/edc_ctrl.sv
// Purpose: Controller that drives an asynchronous 1M x 16 extended-data-out memory by its pins.
// Assumes: Inputs synchronous to clk; all memory timing held by clock counts.
// Notes:   One access per row cycle; refresh runs by column-before-row cycles.
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl #(
    parameter int WAKE_CYC    = edc_pkg::WAKE_CYC_DEF,
    parameter int REF_INT_CYC = edc_pkg::REF_INT_CYC_DEF
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    // User request
    input  wire logic                         req_valid,
    input  wire logic                         req_write,
    input  wire logic [19:0]                  req_addr,
    input  wire logic [1:0]                   req_byte_en,
    input  wire logic [edc_pkg::DATA_W-1:0]   req_wdata,
    output logic                              req_ready,
    output logic                              rsp_valid,
    output logic [edc_pkg::DATA_W-1:0]        rsp_rdata,
    output logic                              init_done,
    // Memory pins
    output logic                              row_strobe_n,
    output logic                              lower_byte_strobe_n,
    output logic                              upper_byte_strobe_n,
    output logic                              write_enable_n,
    output logic                              output_enable_n,
    output logic [edc_pkg::ADDR_W-1:0]        mem_addr,
    input  wire logic [edc_pkg::DATA_W-1:0]   mem_dq_in,
    output logic [edc_pkg::DATA_W-1:0]        mem_dq_out,
    output logic [1:0]                        mem_dq_oe
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam int CW = 24;
    if (WAKE_CYC < 1 || WAKE_CYC >= (1 << CW) || REF_INT_CYC < 16 || REF_INT_CYC >= (1 << CW))
    begin : g_bad_counts
        $error("edc_ctrl: counts out of range");
    end
    localparam logic [CW-1:0] RAS_C  = CW'(edc_pkg::RAS_CYC);
    localparam logic [CW-1:0] RP_C   = CW'(edc_pkg::RP_CYC);
    localparam logic [CW-1:0] CP_C   = CW'(edc_pkg::CP_CYC);
    localparam logic [CW-1:0] AR_C   = CW'(edc_pkg::AR_CYC);
    localparam logic [CW-1:0] ACC_C  = CW'(edc_pkg::ACCESS_CYC);
    localparam logic [CW-1:0] WAKE_C = CW'(WAKE_CYC);
    localparam logic [CW-1:0] REF_C  = CW'(REF_INT_CYC);
    localparam logic [3:0]    INIT_C = 4'(edc_pkg::WAKE_CYCLES);

    // ------------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------------
    edc_pkg::edc_state_t state;
    logic [CW-1:0]       wait_cnt;
    logic [CW-1:0]       ras_cnt;
    logic [CW-1:0]       ref_cnt;
    logic [CW-1:0]       ref_late;
    logic [3:0]          init_cnt;
    logic                ref_due;
    logic                cur_write;
    logic [9:0]          cur_col;
    logic [1:0]          cur_be;
    logic [edc_pkg::DATA_W-1:0] cur_wdata;

    // Refresh interval timer; it runs free so that refreshes keep their average spacing.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ref_cnt  <= '0;
            ref_due  <= 1'b0;
            ref_late <= '0;
        end
        else
        begin
            ref_cnt <= (!init_done || ref_cnt == REF_C - 1'b1) ? '0 : ref_cnt + 1'b1;
            if (init_done && ref_cnt == REF_C - 1'b1)
            begin
                ref_due <= 1'b1;
            end
            else if (!init_done || state == edc_pkg::EDC_REF_CAS)
            begin
                ref_due <= 1'b0;
            end
            ref_late <= (init_done && ref_due && state != edc_pkg::EDC_REF_CAS) ?
                        ref_late + 1'b1 : '0;
        end
    end

    // Main sequencer.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state               <= edc_pkg::EDC_WAKE;
            wait_cnt            <= '0;
            ras_cnt             <= '0;
            init_cnt            <= '0;
            init_done           <= 1'b0;
            req_ready           <= 1'b0;
            rsp_valid           <= 1'b0;
            rsp_rdata           <= '0;
            row_strobe_n        <= 1'b1;
            lower_byte_strobe_n <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            write_enable_n      <= 1'b1;
            output_enable_n     <= 1'b1;
            mem_addr            <= '0;
            mem_dq_out          <= '0;
            mem_dq_oe           <= 2'b00;
            cur_write           <= 1'b0;
            cur_col             <= '0;
            cur_be              <= 2'b00;
            cur_wdata           <= '0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            wait_cnt  <= wait_cnt + 1'b1;
            ras_cnt   <= ras_cnt + 1'b1;
            case (state)
                edc_pkg::EDC_WAKE:
                begin
                    if (wait_cnt >= WAKE_C - 1'b1)
                    begin
                        state        <= edc_pkg::EDC_INIT_RAS;
                        row_strobe_n <= 1'b0;
                        ras_cnt      <= '0;
                    end
                end
                edc_pkg::EDC_INIT_RAS:
                begin
                    if (ras_cnt >= RAS_C - 1'b1)
                    begin
                        row_strobe_n <= 1'b1;
                        wait_cnt     <= '0;
                        init_cnt     <= init_cnt + 1'b1;
                        state        <= edc_pkg::EDC_INIT_PRE;
                    end
                end
                edc_pkg::EDC_INIT_PRE:
                begin
                    if (wait_cnt >= RP_C - 1'b1)
                    begin
                        if (init_cnt == INIT_C)
                        begin
                            init_done <= 1'b1;
                            state     <= edc_pkg::EDC_IDLE;
                        end
                        else
                        begin
                            row_strobe_n <= 1'b0;
                            mem_addr     <= 10'(init_cnt);
                            ras_cnt      <= '0;
                            state        <= edc_pkg::EDC_INIT_RAS;
                        end
                    end
                end
                edc_pkg::EDC_IDLE:
                begin
                    mem_dq_oe <= 2'b00;
                    if (ref_late >= REF_C)
                    begin
                        init_done <= 1'b0;
                        init_cnt  <= '0;
                        wait_cnt  <= RP_C;
                        state     <= edc_pkg::EDC_INIT_PRE;
                    end
                    else if (ref_due)
                    begin
                        lower_byte_strobe_n <= 1'b0;
                        upper_byte_strobe_n <= 1'b0;
                        wait_cnt            <= '0;
                        state               <= edc_pkg::EDC_REF_CAS;
                    end
                    else if (req_valid && (|req_byte_en))
                    begin
                        req_ready    <= 1'b1;
                        cur_write    <= req_write;
                        cur_col      <= req_addr[9:0];
                        cur_be       <= req_byte_en;
                        cur_wdata    <= req_wdata;
                        mem_addr     <= req_addr[19:10];
                        row_strobe_n <= 1'b0;
                        ras_cnt      <= '0;
                        wait_cnt     <= '0;
                        state        <= edc_pkg::EDC_ROW;
                    end
                end
                edc_pkg::EDC_ROW:
                begin
                    mem_addr <= cur_col;
                    if (cur_write)
                    begin
                        write_enable_n <= 1'b0;
                        mem_dq_out     <= cur_wdata;
                        mem_dq_oe      <= cur_be;
                    end
                    else
                    begin
                        write_enable_n  <= 1'b1;
                        output_enable_n <= 1'b0;
                    end
                    wait_cnt <= '0;
                    state    <= edc_pkg::EDC_COL;
                end
                edc_pkg::EDC_COL:
                begin
                    lower_byte_strobe_n <= ~cur_be[0];
                    upper_byte_strobe_n <= ~cur_be[1];
                    wait_cnt            <= '0;
                    state               <= edc_pkg::EDC_HOLD;
                end
                edc_pkg::EDC_HOLD:
                begin
                    if (wait_cnt >= ACC_C && ras_cnt >= AR_C && ras_cnt >= RAS_C - 1'b1)
                    begin
                        if (!cur_write)
                        begin
                            rsp_rdata <= mem_dq_in;
                            rsp_valid <= 1'b1;
                        end
                        row_strobe_n        <= 1'b1;
                        lower_byte_strobe_n <= 1'b1;
                        upper_byte_strobe_n <= 1'b1;
                        write_enable_n      <= 1'b1;
                        output_enable_n     <= 1'b1;
                        mem_dq_oe           <= 2'b00;
                        wait_cnt            <= '0;
                        state               <= edc_pkg::EDC_PRE;
                    end
                end
                edc_pkg::EDC_REF_CAS:
                begin
                    row_strobe_n <= 1'b0;
                    mem_dq_oe    <= 2'b00;
                    ras_cnt      <= '0;
                    state        <= edc_pkg::EDC_REF_RAS;
                end
                edc_pkg::EDC_REF_RAS:
                begin
                    if (ras_cnt >= RAS_C - 1'b1)
                    begin
                        row_strobe_n        <= 1'b1;
                        lower_byte_strobe_n <= 1'b1;
                        upper_byte_strobe_n <= 1'b1;
                        wait_cnt            <= '0;
                        state               <= edc_pkg::EDC_PRE;
                    end
                end
                edc_pkg::EDC_PRE:
                begin
                    if (wait_cnt >= RP_C - 1'b1 && wait_cnt >= CP_C - 1'b1)
                    begin
                        state <= edc_pkg::EDC_IDLE;
                    end
                end
                default:
                begin
                    state <= edc_pkg::EDC_IDLE;
                end
            endcase
        end
    end

endmodule : edc_ctrl
`default_nettype wire

// file: verification/edc_mem_model.sv
// Purpose: Behavioural model of the 1M x 16 strobe memory.
// Assumes: Pins come from the controller; dq is the resolved bus level.
// Notes:   Lanes not driven show the inverse of the word latched at the last row strobe rise, read or written.
`timescale 1ns/1ps
`default_nettype none
module edc_mem_model (
    // Memory pins
    input  wire logic        row_strobe_n,
    input  wire logic        lower_byte_strobe_n,
    input  wire logic        upper_byte_strobe_n,
    input  wire logic        write_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic [9:0]  mem_addr,
    input  wire logic [15:0] dq,
    output logic [15:0]      dq_drive,
    // Observation
    output int               refresh_count
);
    logic [15:0] cells [bit [19:0]];
    logic [9:0]  row = 10'h000;
    logic [9:0]  col = 10'h000;
    logic [8:0]  ref_row = 9'h000;
    logic        refresh = 1'b0;
    logic [15:0] rd = 16'h0000;
    logic [15:0] held = 16'h0000;
    wire         cas_n = lower_byte_strobe_n & upper_byte_strobe_n;
    wire         act = !row_strobe_n && !refresh && write_enable_n && !output_enable_n;
    wire #30     late = act;
    initial refresh_count = 0;
    always @(negedge row_strobe_n)
    begin
        row = mem_addr;
        refresh = !cas_n;
        if (refresh)
            ref_row = ref_row + 9'h001;
        if (refresh)
            refresh_count++;
    end
    always @(negedge cas_n)
    begin
        col = mem_addr;
        rd = cells.exists({row, col}) ? cells[{row, col}] : 16'h0000;
        if (!row_strobe_n && !write_enable_n && !lower_byte_strobe_n)
            rd[7:0] = dq[7:0];
        if (!row_strobe_n && !write_enable_n && !upper_byte_strobe_n)
            rd[15:8] = dq[15:8];
        if (!row_strobe_n && !write_enable_n)
            cells[{row, col}] = rd;
    end
    always @(posedge row_strobe_n)
        held = rd;
    assign dq_drive[7:0] = (act && late && !lower_byte_strobe_n) ? rd[7:0] : ~held[7:0];
    assign dq_drive[15:8] = (act && late && !upper_byte_strobe_n) ? rd[15:8] : ~held[15:8];
endmodule : edc_mem_model
`default_nettype wire

// file: verification/edc_ctrl_sva.sv
// Purpose: Port assertions for the strobe controller.
// Assumes: One clock domain, reset_n asynchronous.
// Notes:   Bound to every controller instance.
`timescale 1ns/1ps
`default_nettype none
module edc_ctrl_sva #(
    parameter int REF_INT_CYC = 40
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Watched ports
    input wire logic [19:0] req_addr,
    input wire logic        req_ready,
    input wire logic        rsp_valid,
    input wire logic        init_done,
    input wire logic        row_strobe_n,
    input wire logic        lower_byte_strobe_n,
    input wire logic        upper_byte_strobe_n,
    input wire logic        write_enable_n,
    input wire logic        output_enable_n,
    input wire logic [9:0]  mem_addr,
    input wire logic [1:0]  mem_dq_oe
);
    wire cas_n = lower_byte_strobe_n & upper_byte_strobe_n;
    wire [9:0] req_row = req_addr[19:10];
    wire [9:0] req_col = req_addr[9:0];
    int  gap;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            gap <= 0;
        else
            gap <= (!init_done || (row_strobe_n && !cas_n)) ? 0 : gap + 1;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    ras_width_a: assert property ($fell(row_strobe_n) |=> !row_strobe_n)
        else $error("row strobe low for under two cycles");
    cycle_end_a: assert property ($rose(row_strobe_n) |-> cas_n)
        else $error("row strobe rose with a byte strobe low");
    read_we_a: assert property (!row_strobe_n && !cas_n && !output_enable_n |-> write_enable_n)
        else $error("write enable low during a read");
    low_data_a: assert property ($fell(lower_byte_strobe_n) && !write_enable_n |-> $past(mem_dq_oe[0]))
        else $error("lower lane undriven at write strobe");
    up_data_a: assert property ($fell(upper_byte_strobe_n) && !write_enable_n |-> $past(mem_dq_oe[1]))
        else $error("upper lane undriven at write strobe");
    addr_split_a: assert property (req_ready |-> !row_strobe_n && mem_addr == $past(req_row)
        ##1 mem_addr == $past(req_col, 2) ##1 mem_addr == $past(req_col, 3))
        else $error("address halves out of order");
    access_time_a: assert property ($fell(cas_n) && write_enable_n && !row_strobe_n |-> !rsp_valid [*2] ##[1:3] rsp_valid)
        else $error("read data taken at the wrong time");
    rsp_idle_a: assert property (rsp_valid |-> row_strobe_n && cas_n)
        else $error("strobes still low at read response");
    wake_gate_a: assert property (!init_done |-> !req_ready)
        else $error("request taken before wake-up");
    ref_order_a: assert property ($fell(row_strobe_n) && !cas_n |-> !$past(cas_n))
        else $error("byte strobe not low ahead of refresh");
    ref_gap_a: assert property (gap <= 2 * REF_INT_CYC)
        else $error("refresh interval exceeded");
    read_c: cover property (rsp_valid);
    write_c: cover property ($fell(cas_n) && !write_enable_n);
    refresh_c: cover property ($fell(row_strobe_n) && !cas_n);
endmodule : edc_ctrl_sva
bind edc_ctrl edc_ctrl_sva #(.REF_INT_CYC(REF_INT_CYC)) i_edc_ctrl_sva (
    .clk, .reset_n, .req_addr, .req_ready, .rsp_valid, .init_done, .row_strobe_n,
    .lower_byte_strobe_n, .upper_byte_strobe_n, .write_enable_n, .output_enable_n,
    .mem_addr, .mem_dq_oe
);
`default_nettype wire

// file: verification/edc_ctrl_test.sv
// Purpose: Self-checking bench for the strobe controller.
// Assumes: Short wake and refresh counts set by parameters.
// Notes:   Inputs change at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module edc_ctrl_test;
    localparam int WAKE = 20;
    localparam int REF = 40;
    logic clk = 1'b0;
    logic reset_n, req_valid, req_write, req_ready, rsp_valid, init_done;
    logic row_strobe_n, lower_byte_strobe_n, upper_byte_strobe_n, write_enable_n;
    logic output_enable_n;
    logic [19:0] req_addr;
    logic [1:0]  req_byte_en, mem_dq_oe;
    logic [15:0] req_wdata, rsp_rdata, mem_dq_out, mdl_out;
    logic [9:0]  mem_addr;
    int num_errors = 0, n_tests = 0, falls = 0, refresh_count;
    wire [15:0] dq = {mem_dq_oe[1] ? mem_dq_out[15:8] : mdl_out[15:8],
                      mem_dq_oe[0] ? mem_dq_out[7:0] : mdl_out[7:0]};
    edc_ctrl #(.WAKE_CYC(WAKE), .REF_INT_CYC(REF)) i_edc_ctrl (
        .clk, .reset_n, .req_valid, .req_write, .req_addr, .req_byte_en, .req_wdata,
        .req_ready, .rsp_valid, .rsp_rdata, .init_done, .row_strobe_n, .lower_byte_strobe_n,
        .upper_byte_strobe_n, .write_enable_n, .output_enable_n, .mem_addr,
        .mem_dq_in(dq), .mem_dq_out, .mem_dq_oe);
    edc_mem_model i_edc_mem_model (.row_strobe_n, .lower_byte_strobe_n, .upper_byte_strobe_n,
        .write_enable_n, .output_enable_n, .mem_addr, .dq, .dq_drive(mdl_out), .refresh_count);
    always #20 clk = ~clk;
    always @(negedge row_strobe_n) falls++;
    task automatic access(input logic wr, input logic [19:0] a, input logic [1:0] be,
                          input logic [15:0] wd, output logic [15:0] rd);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_byte_en = be;
        req_wdata = wd;
        while (req_ready !== 1'b1 && n < 200) begin @(negedge clk); n++; end
        @(negedge clk);
        req_valid = 1'b0;
        while (!wr && rsp_valid !== 1'b1 && n < 250) begin @(negedge clk); n++; end
        rd = rsp_rdata;
        `CHK(n < 200, 1'b1)
        @(negedge clk);
    endtask : access
    task automatic t_wake;
        int cyc;
        cyc = 0;
        while (init_done !== 1'b1 && cyc < 500) begin @(negedge clk); cyc++; end
        `CHK(cyc, WAKE + edc_pkg::WAKE_CYCLES * (edc_pkg::RAS_CYC + edc_pkg::RP_CYC))
        `CHK(falls, edc_pkg::WAKE_CYCLES)
        $display("wake test done");
    endtask : t_wake
    task automatic t_word;
        logic [19:0] a [3];
        logic [15:0] rd;
        a = '{20'h12345, 20'h02345, 20'hfffff};
        foreach (a[i]) access(1'b1, a[i], 2'b11, 16'hbe00 ^ 16'(i), rd);
        foreach (a[i]) begin access(1'b0, a[i], 2'b11, 16'h0000, rd);
            `CHK(rd, 16'hbe00 ^ 16'(i))
        end
        $display("word test done");
    endtask : t_word
    task automatic t_bytes;
        logic [15:0] rd;
        access(1'b1, 20'h00abc, 2'b11, 16'haaaa, rd);
        access(1'b1, 20'h00abc, 2'b01, 16'hff5c, rd);
        access(1'b0, 20'h00abc, 2'b11, 16'h0000, rd);
        `CHK(rd, 16'haa5c)
        access(1'b1, 20'h00abc, 2'b10, 16'h3cff, rd);
        access(1'b0, 20'h00abc, 2'b10, 16'h0000, rd);
        `CHK(rd[15:8], 8'h3c)
        $display("byte test done");
    endtask : t_bytes
    task automatic t_refuse;
        int seen;
        seen = 0;
        req_valid = 1'b1;
        req_byte_en = 2'b00;
        repeat (30) begin @(negedge clk); seen += int'(req_ready === 1'b1); end
        req_valid = 1'b0;
        `CHK(seen, 0)
        $display("refuse test done");
    endtask : t_refuse
    task automatic t_refresh;
        int r0;
        logic [15:0] rd;
        r0 = refresh_count;
        repeat (10 * REF) @(negedge clk);
        `CHK(refresh_count - r0 >= 9, 1'b1)
        `CHK(refresh_count - r0 <= 11, 1'b1)
        access(1'b0, 20'h12345, 2'b11, 16'h0000, rd);
        `CHK(rd, 16'hbe00)
        $display("refresh test done");
    endtask : t_refresh
    task automatic test_done;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 20'h00000;
        req_byte_en = 2'b00;
        req_wdata = 16'h0000;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        t_wake;
        t_word;
        t_bytes;
        t_refuse;
        t_refresh;
        test_done;
    end
    initial begin
        #(40 * 20000);
        num_errors++;
        test_done;
    end
endmodule : edc_ctrl_test
`default_nettype wire
